// *** core/sew_array.sv ***
// Word array with one write port and one registered read port.
`timescale 1ns/10ps
`default_nettype none
module sew_array
  import sew_pkg::*;
#(
  parameter int DEPTH = SEW_DEPTH_DEF,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [SEW_WORD_BITS-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [SEW_WORD_BITS-1:0] rd_data
);

  logic [SEW_WORD_BITS-1:0] mem [DEPTH];

  // Contents survive the logic reset, as nonvolatile storage would.
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// *** core/sew_pkg.sv ***
// Package with constants and carrier types for the serial word EEPROM interface.
package sew_pkg;

  localparam int SEW_FRAME_BITS = 32;
  localparam int SEW_OPC_BITS = 8;
  localparam int SEW_HDR_BITS = 16;
  localparam int SEW_WORD_BITS = 16;
  localparam int SEW_DEPTH_DEF = 512;
  localparam logic [7:0] SEW_OPC_READ = 8'ha8;
  localparam logic [7:0] SEW_OPC_WRITE = 8'ha4;
  localparam logic [7:0] SEW_OPC_WRITE_ENABLE_CMD = 8'ha3;
  localparam logic [7:0] SEW_OPC_WRITE_DISABLE_CMD = 8'ha0;
  localparam logic [6:0] SEW_OPC_RW_HI = 7'h54;
  localparam logic [15:0] SEW_WORD_RST = 16'hffff;
  localparam logic SEW_WEL_RST = 1'b0;
  localparam int SEW_CLK_MHZ = 125;
  localparam int SEW_TWR_US = 4000;
  localparam int SEW_TWR_CYC = SEW_TWR_US * SEW_CLK_MHZ;

  typedef enum logic [1:0] {
    SEW_CMD_NONE,
    SEW_CMD_READ,
    SEW_CMD_WRITE,
    SEW_CMD_WEL
  } sew_cmd_t;

  // Pins as they arrive from the host side.
  typedef struct packed {
    logic cs_n;
    logic serial_clock_n;
    logic serial_data_in;
    logic reset;
  } sew_pins_t;

  // Two-signal form of the serial data output.
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } sew_dout_t;

endpackage

// *** core/sew_sync.sv ***
// Two-flop synchroniser for the pin group, with edge strobes for clock and select.
`timescale 1ns/10ps
`default_nettype none
module sew_sync
  import sew_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Raw pins
  input wire sew_pins_t pins_in,
  // Synchronised levels and strobes
  output sew_pins_t pins_sync,
  output logic clk_rise,
  output logic clk_fall,
  output logic cs_fall,
  output logic cs_rise
);

  sew_pins_t meta_q;
  sew_pins_t sync_q;
  sew_pins_t prev_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      meta_q <= '{cs_n: 1'b1, serial_clock_n: 1'b1, serial_data_in: 1'b0, reset: 1'b0};
      sync_q <= '{cs_n: 1'b1, serial_clock_n: 1'b1, serial_data_in: 1'b0, reset: 1'b0};
      prev_q <= '{cs_n: 1'b1, serial_clock_n: 1'b1, serial_data_in: 1'b0, reset: 1'b0};
    end
    else
    begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pins_sync = sync_q;
  assign clk_rise = sync_q.serial_clock_n && !prev_q.serial_clock_n;
  assign clk_fall = !sync_q.serial_clock_n && prev_q.serial_clock_n;
  assign cs_fall = !sync_q.cs_n && prev_q.cs_n;
  assign cs_rise = sync_q.cs_n && !prev_q.cs_n;

endmodule
`default_nettype wire

// *** core/sew_top.sv ***
// Device side of a three-wire serial word EEPROM: framing, protection, self-timed write.
//
// Contract
// - 16-bit words, depth 128, 256 or 512.
// - Sample serial input on serial clock rising.
// - Shift read data out on falling edge.
// - Frame is opcode, address, two data bytes.
// - Select falling with clock high starts session.
// - Select rising early abandons the instruction.
// - Select falling with clock low gives status.
// - Status lasts until select rises or opcode one.
// - Data output floats outside status and read.
// - Instructions refused during self-timed write.
// - Ready/busy pin low exactly while writing.
// - Write starts self-timed erase then program.
// - Writes blocked after power-up and disable.
// - Enable latch persists until write disable.
// - Reads ignore the write enable latch.
// - Reset high at write refuses the write.
// - Reset high during write aborts to ready.
// - Read and latch commands ignore reset pin.
// - Write completes without select or clock.
// - Reads auto-increment the word address.
// - Opcode values; 512 words puts A8 in opcode.
// - Write period starts after thirty-second bit.
// - Read output starts at seventeenth falling edge.
// - Read address wraps from top to zero.
`timescale 1ns/10ps
`default_nettype none
module sew_top
  import sew_pkg::*;
#(
  parameter int DEPTH = SEW_DEPTH_DEF,
  parameter int TWR_CYC = SEW_TWR_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic cs_n,
  input wire logic serial_clock_n,
  input wire logic serial_data_in,
  input wire logic reset_pin,
  // Data output as value and enable
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // Ready/busy pin, low while writing
  output logic ready_busy_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(TWR_CYC + 1);

  typedef enum logic [2:0] {
    SEW_ST_IDLE,
    SEW_ST_STATUS,
    SEW_ST_SHIFT,
    SEW_ST_READ,
    SEW_ST_WAIT
  } sew_state_t;

  sew_pins_t pins_raw;
  sew_pins_t pins;
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;
  logic cs_rise;

  sew_state_t state_q;
  logic [5:0] bit_cnt_q;
  logic [SEW_FRAME_BITS-1:0] shift_q;
  logic [AW-1:0] addr_q;
  logic [SEW_WORD_BITS-1:0] out_word_q;
  logic [3:0] out_idx_q;
  logic out_on_q;
  logic wel_q;
  logic busy_q;
  logic [CW-1:0] twr_cnt_q;
  logic [AW-1:0] wr_addr_q;
  logic [SEW_WORD_BITS-1:0] wr_data_q;
  logic wr_commit;
  logic [SEW_WORD_BITS-1:0] commit_data;
  logic [SEW_WORD_BITS-1:0] rd_data;
  sew_dout_t dout_q;

  logic [5:0] bits_next;
  logic [SEW_FRAME_BITS-1:0] shift_next;
  logic [7:0] opc_next;
  logic [AW-1:0] hdr_addr;

  // Decodes the opcode byte into a command, folding the top address bit in for 512 words.
  function automatic sew_cmd_t decode_cmd(input logic [7:0] opc);
    decode_cmd = SEW_CMD_NONE;
    if (DEPTH > 256 && opc[7:1] == SEW_OPC_RW_HI)
    begin
      decode_cmd = SEW_CMD_READ;
    end
    else if (DEPTH > 256 && opc[7:1] == SEW_OPC_WRITE[7:1])
    begin
      decode_cmd = SEW_CMD_WRITE;
    end
    else if (opc == SEW_OPC_READ)
    begin
      decode_cmd = SEW_CMD_READ;
    end
    else if (opc == SEW_OPC_WRITE)
    begin
      decode_cmd = SEW_CMD_WRITE;
    end
    else if (opc == SEW_OPC_WRITE_ENABLE_CMD || opc == SEW_OPC_WRITE_DISABLE_CMD)
    begin
      decode_cmd = SEW_CMD_WEL;
    end
  endfunction

  assign pins_raw = '{cs_n: cs_n, serial_clock_n: serial_clock_n,
                      serial_data_in: serial_data_in, reset: reset_pin};

  sew_sync u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pins_in(pins_raw),
    .pins_sync(pins),
    .clk_rise(clk_rise),
    .clk_fall(clk_fall),
    .cs_fall(cs_fall),
    .cs_rise(cs_rise)
  );

  sew_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_array (
    .sys_clk(sys_clk),
    .wr_en(wr_commit),
    .wr_addr(wr_addr_q),
    .wr_data(commit_data),
    .rd_addr(addr_q),
    .rd_data(rd_data)
  );

  assign bits_next = bit_cnt_q + 6'h01;
  assign shift_next = {shift_q[SEW_FRAME_BITS-2:0], pins.serial_data_in};
  assign opc_next = shift_next[15:8];
  // The address byte lands in the low byte once sixteen bits are in.
  always_comb
  begin
    hdr_addr = '0;
    if (DEPTH > 256)
    begin
      hdr_addr = AW'({shift_next[8], shift_next[7:0]});
    end
    else if (DEPTH > 128)
    begin
      hdr_addr = AW'(shift_next[7:0]);
    end
    else
    begin
      hdr_addr = AW'(shift_next[7:1]);
    end
  end

  // Session sequencing.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q <= SEW_ST_IDLE;
      bit_cnt_q <= 6'h00;
      shift_q <= '0;
    end
    else if (pins.cs_n || cs_rise)
    begin
      state_q <= SEW_ST_IDLE;
      bit_cnt_q <= 6'h00;
    end
    else if (cs_fall)
    begin
      bit_cnt_q <= 6'h00;
      if (!pins.serial_clock_n)
      begin
        state_q <= SEW_ST_STATUS;
      end
      else if (busy_q)
      begin
        state_q <= SEW_ST_WAIT;
      end
      else
      begin
        state_q <= SEW_ST_SHIFT;
      end
    end
    else
    begin
      unique case (state_q)
        SEW_ST_IDLE, SEW_ST_WAIT, SEW_ST_READ:
        begin
          state_q <= state_q;
        end
        SEW_ST_STATUS:
        begin
          if (clk_rise && pins.serial_data_in && !busy_q)
          begin
            state_q <= SEW_ST_SHIFT;
            shift_q <= shift_next;
            bit_cnt_q <= 6'h01;
          end
        end
        SEW_ST_SHIFT:
        begin
          if (clk_rise)
          begin
            shift_q <= shift_next;
            bit_cnt_q <= bits_next;
            if (bits_next == 6'(SEW_HDR_BITS))
            begin
              unique case (decode_cmd(opc_next))
                SEW_CMD_READ: state_q <= SEW_ST_READ;
                SEW_CMD_WEL: state_q <= SEW_ST_WAIT;
                SEW_CMD_WRITE: state_q <= SEW_ST_SHIFT;
                SEW_CMD_NONE: state_q <= SEW_ST_WAIT;
              endcase
            end
            else if (bits_next == 6'(SEW_FRAME_BITS))
            begin
              state_q <= SEW_ST_WAIT;
            end
          end
        end
      endcase
    end
  end

  // Write enable latch, set and cleared at the end of the header.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wel_q <= SEW_WEL_RST;
    end
    else if (state_q == SEW_ST_SHIFT && !pins.cs_n && !cs_rise && clk_rise &&
             bits_next == 6'(SEW_HDR_BITS))
    begin
      if (opc_next == SEW_OPC_WRITE_ENABLE_CMD)
      begin
        wel_q <= 1'b1;
      end
      else if (opc_next == SEW_OPC_WRITE_DISABLE_CMD)
      begin
        wel_q <= 1'b0;
      end
    end
  end

  // Self-timed write; it runs on the system clock alone.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      twr_cnt_q <= '0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end
    else if (busy_q)
    begin
      if (wr_commit)
      begin
        busy_q <= 1'b0;
      end
      twr_cnt_q <= twr_cnt_q + CW'(1);
    end
    else if (state_q == SEW_ST_SHIFT && !pins.cs_n && !cs_rise && clk_rise &&
             bits_next == 6'(SEW_FRAME_BITS) && wel_q && !pins.reset)
    begin
      busy_q <= 1'b1;
      twr_cnt_q <= '0;
      wr_addr_q <= addr_q;
      wr_data_q <= shift_next[15:0];
    end
  end

  // Erase and programme commit together at the end; an abort leaves a scrambled word.
  assign wr_commit = busy_q && (pins.reset || twr_cnt_q == CW'(TWR_CYC - 1));
  assign commit_data = pins.reset ? ~wr_data_q : wr_data_q;

  // Word address: loaded from the header, stepped as each word enters the shifter.
  // The array read port then has a whole word time to fetch the following word.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      addr_q <= '0;
    end
    else if (state_q == SEW_ST_SHIFT && clk_rise && bits_next == 6'(SEW_HDR_BITS))
    begin
      addr_q <= hdr_addr;
    end
    else if (state_q == SEW_ST_READ && clk_fall && (out_idx_q == 4'h0 || !out_on_q))
    begin
      addr_q <= addr_q + AW'(1);
    end
  end

  // Read shifter: one bit per falling edge, most significant first.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      out_word_q <= '0;
      out_idx_q <= 4'hf;
      out_on_q <= 1'b0;
    end
    else if (state_q != SEW_ST_READ)
    begin
      out_on_q <= 1'b0;
      out_idx_q <= 4'hf;
    end
    else if (clk_fall)
    begin
      if (!out_on_q || out_idx_q == 4'h0)
      begin
        out_word_q <= rd_data;
        out_on_q <= 1'b1;
        out_idx_q <= 4'hf;
      end
      else
      begin
        out_idx_q <= out_idx_q - 4'h1;
      end
    end
  end

  // Data output pin, driven only in status mode or while reading.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      dout_q <= '{dout: 1'b0, dout_oe: 1'b0};
    end
    else if (state_q == SEW_ST_STATUS && !pins.cs_n)
    begin
      dout_q <= '{dout: !busy_q, dout_oe: 1'b1};
    end
    else if (state_q == SEW_ST_READ && out_on_q && !pins.cs_n)
    begin
      dout_q <= '{dout: out_word_q[out_idx_q], dout_oe: 1'b1};
    end
    else
    begin
      dout_q <= '{dout: 1'b0, dout_oe: 1'b0};
    end
  end

  assign serial_data_out = dout_q.dout;
  assign serial_data_out_oe = dout_q.dout_oe;
  assign ready_busy_n = !busy_q;

endmodule
`default_nettype wire

// *** verif/sew_host.sv ***
// Host serial port model that frames instructions and captures output bits.
`timescale 1ns/10ps
`default_nettype none
module sew_host
(
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic cs_n,
  output logic serial_clock_n,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  // Captured word and its strobe
  output logic [15:0] rd_word,
  output logic rd_stb
);
  initial
  begin
    cs_n = 1'b1;
    serial_clock_n = 1'b1;
    serial_data_in = 1'b0;
    rd_word = 16'h0;
    rd_stb = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Bits change in the low phase; the output is sampled just before the rise.
  // With st set, select falls with the clock low and the opcode leaves status mode.
  task automatic frame(input logic [31:0] bits, input int nb, input int nw, input logic st);
    logic [15:0] w;
    w = 16'h0;
    if (st)
    begin
      serial_clock_n <= 1'b0;
      tick(4);
    end
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < nb + 16 * nw; i++)
    begin
      serial_clock_n <= 1'b0;
      serial_data_in <= (i < nb) ? bits[31 - i] : ~serial_data_in;
      tick(5);
      #1 w = {w[14:0], serial_data_out & serial_data_out_oe};
      tick(1);
      serial_clock_n <= 1'b1;
      rd_word <= w;
      rd_stb <= (i >= nb) && ((i - nb) % 16 == 15);
      tick(1);
      rd_stb <= 1'b0;
      tick(3);
    end
    tick(2);
    cs_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    tick(6);
  endtask
  task automatic status();
    logic [1:0] s;
    serial_clock_n <= 1'b0;
    tick(3);
    cs_n <= 1'b0;
    tick(7);
    #1 s = {serial_data_out_oe, serial_data_out};
    tick(1);
    rd_word <= {14'h0, s};
    rd_stb <= 1'b1;
    cs_n <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
    tick(2);
    serial_clock_n <= 1'b1;
    tick(6);
  endtask
endmodule
`default_nettype wire

// *** verif/sew_top_assertions.sv ***
// Concurrent checks on the device-side pins of the serial word EEPROM.
`timescale 1ns/10ps
`default_nettype none
module sew_top_assertions
#(
  parameter int TWR_CYC = 600
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins
  input wire logic cs_n,
  input wire logic serial_clock_n,
  input wire logic reset_pin,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic ready_busy_n
);
  logic [31:0] busy_cnt_q;
  logic abort_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk)
  begin
    busy_cnt_q <= (!rst_b || ready_busy_n) ? 32'h0 : busy_cnt_q + 32'h1;
  end
  // Remembers that the running write was cut short by the reset pin.
  always_ff @(posedge sys_clk)
  begin
    abort_q <= rst_b && !ready_busy_n && (abort_q || reset_pin);
  end
  sequence s_status_req;
    $fell(cs_n) && !serial_clock_n && !$past(serial_clock_n, 3);
  endsequence
  sequence s_status_out;
    ##[3:6] (serial_data_out_oe && serial_data_out == ready_busy_n);
  endsequence
  chk_status_shown: assert property (s_status_req |-> s_status_out)
    else $error("status not driven");
  chk_idle_float: assert property (cs_n [*6] |-> !serial_data_out_oe)
    else $error("output driven while deselected");
  chk_oe_selected: assert property ($rose(serial_data_out_oe) |-> !cs_n)
    else $error("output enabled outside a session");
  chk_dout_held: assert property ((serial_clock_n && serial_data_out_oe) [*2] |->
    $stable(serial_data_out))
    else $error("output changed while clock high");
  chk_busy_start: assert property ($fell(ready_busy_n) |-> !cs_n && !reset_pin)
    else $error("busy started without a write frame");
  chk_busy_len: assert property ($rose(ready_busy_n) && !abort_q |->
    busy_cnt_q == TWR_CYC)
    else $error("busy period length wrong");
  chk_abort_ready: assert property (!ready_busy_n && reset_pin |-> ##[1:6] ready_busy_n)
    else $error("busy not ended by reset pin");
  chk_busy_refuse: assert property (!ready_busy_n && serial_data_out_oe |->
    !serial_data_out)
    else $error("data driven during busy");
endmodule
`default_nettype wire

// *** verif/sew_top_test.sv ***
// Self-checking bench for the serial word EEPROM device side.
`timescale 1ns/10ps
`default_nettype none
module sew_top_test
  import sew_pkg::*;
();
  localparam int TWR = 600;
  logic sys_clk;
  logic rst_b;
  logic reset_pin;
  logic cs_n;
  logic serial_clock_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic ready_busy_n;
  logic [15:0] rd_word;
  logic rd_stb;
  logic [15:0] d [3];
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 18;
  sew_top #(.DEPTH(256), .TWR_CYC(TWR)) sew_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n), .serial_clock_n(serial_clock_n),
    .serial_data_in(serial_data_in), .reset_pin(reset_pin),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .ready_busy_n(ready_busy_n));
  sew_host sew_host_i (
    .sys_clk(sys_clk), .cs_n(cs_n), .serial_clock_n(serial_clock_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .rd_word(rd_word), .rd_stb(rd_stb));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input logic e);
    cmp_word("ready_busy_n", {15'h0, e}, {15'h0, ready_busy_n});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dv, input logic idle);
    sew_host_i.frame({SEW_OPC_WRITE, a, dv}, 32, 0, 1'b0);
    cmp_bit(idle);
  endtask
  task automatic cmd(input logic [7:0] op);
    sew_host_i.frame({op, 8'($random(seed)), 16'h0}, 16, 0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    sew_host_i.frame({SEW_OPC_READ, a, 16'h0}, 16, n, 1'b0);
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 2 * TWR && ready_busy_n !== 1'b1; i++)
      @(posedge sys_clk);
    cmp_bit(1'b1);
  endtask
  always @(posedge sys_clk)
  begin
    if (rd_stb === 1'b1)
      cmp_word("rd_word", exp_q.size() ? exp_q.pop_front() : 16'hxxxx, rd_word);
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    reset_pin = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    foreach (d[i])
      d[i] = $random(seed);
    exp_q.push_back(16'h0003);
    sew_host_i.status();
    cmd(SEW_OPC_WRITE_ENABLE_CMD);
    wr(8'hff, d[0], 1'b0);
    wait_rdy();
    wr(8'h00, d[1], 1'b0);
    wait_rdy();
    cmd(SEW_OPC_WRITE_DISABLE_CMD);
    wr(8'hff, ~d[0], 1'b1);
    cmd(SEW_OPC_WRITE_ENABLE_CMD);
    reset_pin <= 1'b1;
    wr(8'h00, ~d[1], 1'b1);
    reset_pin <= 1'b0;
    sew_host_i.frame({SEW_OPC_WRITE, 8'h00, ~d[1]}, 24, 0, 1'b0);
    cmp_bit(1'b1);
    reset_pin <= 1'b1;
    exp_q.push_back(d[0]);
    exp_q.push_back(d[1]);
    rd(8'hff, 2);
    reset_pin <= 1'b0;
    wr(8'h01, d[2], 1'b0);
    exp_q.push_back(16'h0002);
    sew_host_i.status();
    exp_q.push_back(16'h0000);
    rd(8'h01, 1);
    reset_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmp_bit(1'b1);
    reset_pin <= 1'b0;
    exp_q.push_back(~d[2]);
    rd(8'h01, 1);
    cmd(SEW_OPC_WRITE_DISABLE_CMD);
    exp_q.push_back(d[0]);
    sew_host_i.frame({SEW_OPC_READ, 8'hff, 16'h0}, 16, 1, 1'b1);
    end_of_test();
  end
endmodule
bind sew_top sew_top_assertions #(.TWR_CYC(TWR_CYC)) sew_top_assertions_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n), .serial_clock_n(serial_clock_n),
  .reset_pin(reset_pin), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire
